// ===== design/dpc_params.svh
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH

// Register offsets (byte addresses)
`define DPC_OFS_PLL_A_CONTROL   16'h6014
`define DPC_OFS_PLL_B_CONTROL   16'h6018
`define DPC_OFS_PLL_A_MULT_DIV  16'h601C
`define DPC_OFS_PLL_B_MULT_DIV  16'h6020
`define DPC_OFS_RAW_CLOCK_FREQ  16'h6024
`define DPC_OFS_POWER_STATE     16'h6104

// Reset values
`define DPC_RST_PLL_A_CONTROL   32'h00002000
`define DPC_RST_PLL_B_CONTROL   32'h00006000
`define DPC_RST_MULT_DIV        32'h00000003
`define DPC_RST_RAW_CLOCK_FREQ  32'h0000007D
`define DPC_RST_POWER_STATE     32'h20D00400

// Writable bit masks
`define DPC_WMASK_PLL_A         32'hFC003F00
`define DPC_WMASK_PLL_B         32'hFC004100
`define DPC_WMASK_MULT_DIV      32'h3F3F3F3F
`define DPC_WMASK_RAW_FREQ      32'h000003FF
`define DPC_WMASK_POWER_STATE   32'hFFFF7F0B

// Control field positions
`define DPC_BIT_VCO_EN          31
`define DPC_BIT_EXT_BUF_EN      30
`define DPC_BIT_REF_EN          29
`define DPC_BIT_LEGACY_DIS      28
`define DPC_SHARE_HI            27
`define DPC_SHARE_LO            26
`define DPC_BIT_LOCK            15
`define DPC_BIT_CRI_SEL         14
`define DPC_BIT_REF_SEL         13
`define DPC_PHASE_HI            12
`define DPC_PHASE_LO            9
`define DPC_BIT_RATE_SW         8
`define DPC_LOCK_HI             31
`define DPC_LOCK_LO             16
`define DPC_MINPD_HI            14
`define DPC_MINPD_LO            8
`define DPC_LEGACY_SEL_HI       3
`define DPC_LEGACY_SEL_LO       2

// Field codes
`define DPC_SHARE_ON            2'h1
`define DPC_PIPE_CFG_RATE_OK    2'h0
`define DPC_PHASE_MIN           4'h4
`define DPC_PHASE_MAX           4'hD
`define DPC_PHASE_DEFAULT       4'h6

// Timing
`define DPC_RAW_PERIOD_NS       5
`define DPC_MINPD_STEP_NS       160
`define DPC_MINPD_STEP_CYC      (`DPC_MINPD_STEP_NS / `DPC_RAW_PERIOD_NS)
`define DPC_VBLANK_ROWS         2

`endif

// ===== design/dpc_pkg.sv
package dpc_pkg;
	typedef enum logic [1:0] {
		DPC_RS_IDLE,
		DPC_RS_WAIT_BLANK,
		DPC_RS_OFF,
		DPC_RS_ON
	} dpc_rs_e;
endpackage : dpc_pkg

// ===== design/dpc_load_pulse.sv
`timescale 1ns/10ps
`include "dpc_params.svh"

// Delays the 1X sync by phase+2 flops in the 10X domain
module dpc_load_pulse #(
	parameter int DEPTH = 16
) (
	input  wire logic       clk_fast,    // 10X serial clock
	input  wire logic       rstn,        // Async reset
	input  wire logic       sync_1x,     // 1X parallel sync
	input  wire logic [3:0] phase,       // Phase code
	output logic            load_pulse   // Parallel to serial load
);
	logic [DEPTH-1:0] chain;

	always_ff @(posedge clk_fast or negedge rstn)
	begin
		if (!rstn)
			chain <= '0;
		else
			chain <= {chain[DEPTH-2:0], sync_1x};
	end

	// Phase N taps chain[N], which is N+1 flops from the input
	always_ff @(posedge clk_fast or negedge rstn)
	begin
		if (!rstn)
			load_pulse <= 1'b0;
		else
			load_pulse <= chain[phase];
	end
endmodule : dpc_load_pulse

// ===== design/dpc_pll_seq.sv
`timescale 1ns/10ps
`include "dpc_params.svh"

// Per-PLL power sequencer: min power-down, relock wait and rate switch
module dpc_pll_seq (
	input  wire logic        clk,          // Raw reference clock
	input  wire logic        rstn,         // Async reset
	input  wire logic        vco_en,       // Software VCO enable
	input  wire logic        rate_sw,      // Rate switch bit
	input  wire logic        rate_ok,      // Pipe config allows switching
	input  wire logic        vblank,       // Vertical blank level
	input  wire logic        row_tick,     // Row start pulse
	input  wire logic [15:0] lock_time,    // Relock wait, 5 ns counts
	input  wire logic [6:0]  min_pd,       // Min power-down, 160 ns steps
	output logic             pll_on,       // Power the PLL
	output logic             locked,       // Lock reached
	output logic             apply_div     // Load new dividers
);
	dpc_pkg::dpc_rs_e state;
	logic        rate_prev;
	logic        pending;
	logic [11:0] pd_cnt;
	logic [15:0] lk_cnt;
	logic [1:0]  rows;
	logic        want_on;
	logic        pd_done;

	assign want_on = vco_en && state != dpc_pkg::DPC_RS_OFF;
	assign pd_done = pd_cnt >= 12'(12'(min_pd) * 12'(`DPC_MINPD_STEP_CYC));

	// Mismatch between the bit and its registered copy flags a switch
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rate_prev <= 1'b0;
		else
			rate_prev <= rate_sw;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pending <= 1'b0;
		else if (rate_sw != rate_prev && rate_ok)
			pending <= 1'b1;
		else if (state == dpc_pkg::DPC_RS_OFF)
			pending <= 1'b0;
	end

	// Off for two rows of vblank, longer if min power-down is not done, then back on with new dividers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state     <= dpc_pkg::DPC_RS_IDLE;
			rows      <= 2'h0;
			apply_div <= 1'b0;
		end
		else
		begin
			apply_div <= 1'b0;
			case (state)
				dpc_pkg::DPC_RS_IDLE:
					if (pending && vco_en)
						state <= dpc_pkg::DPC_RS_WAIT_BLANK;
				dpc_pkg::DPC_RS_WAIT_BLANK:
					if (vblank && row_tick)
					begin
						state <= dpc_pkg::DPC_RS_OFF;
						rows  <= 2'h0;
					end
				dpc_pkg::DPC_RS_OFF:
					if (row_tick)
					begin
						rows <= rows + 2'h1;
						if (rows == 2'(`DPC_VBLANK_ROWS - 1) && pd_done)
						begin
							state     <= dpc_pkg::DPC_RS_ON;
							apply_div <= 1'b1;
						end
					end
				default:
					state <= dpc_pkg::DPC_RS_IDLE;
			endcase
		end
	end

	// Min power-down time counted in raw clocks
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pd_cnt <= 12'hFFF;
		else if (pll_on)
			pd_cnt <= 12'h000;
		else if (!pd_done)
			pd_cnt <= pd_cnt + 12'h001;
	end

	// A cleared enable powers down at once; re-enable waits for min power-down
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pll_on <= 1'b0;
		else if (!want_on)
			pll_on <= 1'b0;
		else if (pd_done)
			pll_on <= 1'b1;
	end

	// Relock wait in 5 ns raw clock counts
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			lk_cnt <= 16'h0000;
			locked <= 1'b0;
		end
		else if (!pll_on)
		begin
			lk_cnt <= 16'h0000;
			locked <= 1'b0;
		end
		else if (lk_cnt >= lock_time)
			locked <= 1'b1;
		else
			lk_cnt <= lk_cnt + 16'h0001;
	end
endmodule : dpc_pll_seq

// ===== design/dpc_ctrl.sv
// Overview of operation
// - Ref select: 0 external pad, 1 core
// - Load phase codes 4 to 13, default 6
// - Load pulse delayed phase plus two flops
// - Rate bit toggle cycles PLL in vblank
// - Rate switch only when pipe config 00
// - PHY status: port two high nibble
// - VCO enable zero means lowest power, default
// - Clearing VCO enable stops dot clock
// - Buffer enable drives PLL clock out
// - Reference enable gates PLL reference clock
// - Legacy writes load selected clock control
// - Sharing code 01 feeds both pipes
// - Interface clock select: 0 pad, 1 core
// - Hi-res divider is pixels minus one
// - Legacy divider uses same encoding
// - Hi-res multiplier is factor minus one
// - Legacy multiplier uses same encoding
// - Raw frequency sets timer divide, reset 7Dh
// - Lock time counts raw clocks at 5 ns
// - Min power-down in 160 ns steps
`timescale 1ns/10ps
`include "dpc_params.svh"

module dpc_ctrl (
	input  wire logic        clk,            // Raw reference clock
	input  wire logic        rstn,           // Async reset, active low
	input  wire logic        reg_wr,         // Register write strobe
	input  wire logic        reg_rd,         // Register read strobe
	input  wire logic [15:0] reg_addr,       // Register byte address
	input  wire logic [31:0] reg_wdata,      // Write data
	output logic      [31:0] reg_rdata,      // Read data
	input  wire logic        legacy_wr,      // Legacy misc output write
	input  wire logic [7:0]  legacy_data,    // Legacy misc output data
	input  wire logic [1:0]  pipe_one_cfg,   // Pipe one config bits 17:16
	input  wire logic        vblank_a,       // Pipe A vblank
	input  wire logic        row_tick_a,     // Pipe A row pulse
	input  wire logic        vblank_b,       // Pipe B vblank
	input  wire logic        row_tick_b,     // Pipe B row pulse
	input  wire logic [7:0]  lane_phy_state, // Lane status, active low, async
	input  wire logic        clk_fast,       // 10X serial clock
	input  wire logic        sync_1x,        // 1X parallel sync
	output logic             load_pulse,     // Parallel to serial load
	output logic      [1:0]  pll_on,         // PLL power per PLL
	output logic      [1:0]  pll_ref_en,     // Reference clock gate
	output logic      [1:0]  pll_ext_buf_en, // External clock buffer
	output logic      [1:0]  pll_dot_clk_en, // Dot clock run
	output logic             pll_a_ref_sel,  // 0 pad, 1 core
	output logic             cri_clk_sel,    // 0 pad, 1 core
	output logic             pll_share,      // One PLL feeds both pipes
	output logic      [1:0]  apply_div,      // Load new dividers
	output logic      [9:0]  raw_freq,       // Timer divide ratio
	output logic             timer_tick,     // Divided timer clock pulse
	output logic      [3:0]  mult_a,         // Active multiplier code A
	output logic      [3:0]  mult_b          // Active multiplier code B
);
	//**********************************************
	// Registers
	//**********************************************
	logic [31:0] pll_a_control;
	logic [31:0] pll_b_control;
	logic [31:0] pll_a_pixel_mult_div;
	logic [31:0] pll_b_pixel_mult_div;
	logic [31:0] raw_clock_frequency;
	logic [31:0] power_state_control;
	logic [7:0]  phy_s1, phy_s2, phy_s3, phy_state;
	logic [1:0]  locked;
	logic [3:0]  next_phase;
	logic [9:0]  tdiv;
	logic        rate_ok;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction : merge

	// Illegal phase codes keep the previous phase
	always_comb
	begin
		next_phase = reg_wdata[`DPC_PHASE_HI:`DPC_PHASE_LO];
		if (next_phase < `DPC_PHASE_MIN || next_phase > `DPC_PHASE_MAX)
			next_phase = pll_a_control[`DPC_PHASE_HI:`DPC_PHASE_LO];
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pll_a_control <= `DPC_RST_PLL_A_CONTROL | (32'(`DPC_PHASE_DEFAULT) << `DPC_PHASE_LO);
		else if (reg_wr && reg_addr == `DPC_OFS_PLL_A_CONTROL)
		begin
			pll_a_control <= merge(pll_a_control, reg_wdata, `DPC_WMASK_PLL_A);
			pll_a_control[`DPC_PHASE_HI:`DPC_PHASE_LO] <= next_phase;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pll_b_control <= `DPC_RST_PLL_B_CONTROL;
		else if (reg_wr && reg_addr == `DPC_OFS_PLL_B_CONTROL)
			pll_b_control <= merge(pll_b_control, reg_wdata, `DPC_WMASK_PLL_B);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pll_a_pixel_mult_div <= `DPC_RST_MULT_DIV;
			pll_b_pixel_mult_div <= `DPC_RST_MULT_DIV;
		end
		else if (reg_wr && reg_addr == `DPC_OFS_PLL_A_MULT_DIV)
			pll_a_pixel_mult_div <= reg_wdata & `DPC_WMASK_MULT_DIV;
		else if (reg_wr && reg_addr == `DPC_OFS_PLL_B_MULT_DIV)
			pll_b_pixel_mult_div <= reg_wdata & `DPC_WMASK_MULT_DIV;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			raw_clock_frequency <= `DPC_RST_RAW_CLOCK_FREQ;
		else if (reg_wr && reg_addr == `DPC_OFS_RAW_CLOCK_FREQ)
			raw_clock_frequency <= reg_wdata & `DPC_WMASK_RAW_FREQ;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			power_state_control <= `DPC_RST_POWER_STATE;
		else if (reg_wr && reg_addr == `DPC_OFS_POWER_STATE)
			power_state_control <= merge(power_state_control, reg_wdata, `DPC_WMASK_POWER_STATE);
	end

	//**********************************************
	// Legacy clock select
	//**********************************************
	// Legacy write chooses which control word drives the active multiplier
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mult_a <= 4'h0;
			mult_b <= 4'h0;
		end
		else if (legacy_wr)
		begin
			if (!pll_a_control[`DPC_BIT_LEGACY_DIS])
				mult_a <= {2'h0, legacy_data[`DPC_LEGACY_SEL_HI:`DPC_LEGACY_SEL_LO]};
			if (!pll_b_control[`DPC_BIT_LEGACY_DIS])
				mult_b <= {2'h0, legacy_data[`DPC_LEGACY_SEL_HI:`DPC_LEGACY_SEL_LO]};
		end
	end

	//**********************************************
	// Status synchroniser
	//**********************************************
	// Lane status is asynchronous; accept a change once stages two and three agree
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			phy_s1    <= 8'hFF;
			phy_s2    <= 8'hFF;
			phy_s3    <= 8'hFF;
			phy_state <= 8'hFF;
		end
		else
		begin
			phy_s1 <= lane_phy_state;
			phy_s2 <= phy_s1;
			phy_s3 <= phy_s2;
			if (phy_s2 == phy_s3)
				phy_state <= phy_s3;
		end
	end

	//**********************************************
	// Read mux
	//**********************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			if (reg_addr == `DPC_OFS_PLL_A_CONTROL)
				reg_rdata <= {pll_a_control[31:16], locked[0], pll_a_control[14:8], phy_state};
			else if (reg_addr == `DPC_OFS_PLL_B_CONTROL)
				reg_rdata <= pll_b_control;
			else if (reg_addr == `DPC_OFS_PLL_A_MULT_DIV)
				reg_rdata <= pll_a_pixel_mult_div;
			else if (reg_addr == `DPC_OFS_PLL_B_MULT_DIV)
				reg_rdata <= pll_b_pixel_mult_div;
			else if (reg_addr == `DPC_OFS_RAW_CLOCK_FREQ)
				reg_rdata <= raw_clock_frequency;
			else if (reg_addr == `DPC_OFS_POWER_STATE)
				reg_rdata <= power_state_control;
			else
				reg_rdata <= 32'h00000000;
		end
	end

	//**********************************************
	// Control outputs
	//**********************************************
	assign rate_ok = pipe_one_cfg == `DPC_PIPE_CFG_RATE_OK;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pll_ref_en     <= 2'h0;
			pll_ext_buf_en <= 2'h0;
			pll_dot_clk_en <= 2'h0;
			pll_a_ref_sel  <= 1'b1;
			cri_clk_sel    <= 1'b1;
			pll_share      <= 1'b0;
		end
		else
		begin
			pll_ref_en     <= {pll_b_control[`DPC_BIT_REF_EN], pll_a_control[`DPC_BIT_REF_EN]};
			pll_ext_buf_en <= {pll_b_control[`DPC_BIT_EXT_BUF_EN] & pll_on[1],
				pll_a_control[`DPC_BIT_EXT_BUF_EN] & pll_on[0]};
			pll_dot_clk_en <= pll_on & locked;
			pll_a_ref_sel  <= pll_a_control[`DPC_BIT_REF_SEL];
			cri_clk_sel    <= pll_b_control[`DPC_BIT_CRI_SEL];
			pll_share      <= pll_a_control[`DPC_SHARE_HI:`DPC_SHARE_LO] == `DPC_SHARE_ON ||
				pll_b_control[`DPC_SHARE_HI:`DPC_SHARE_LO] == `DPC_SHARE_ON;
		end
	end

	assign raw_freq = raw_clock_frequency[9:0];

	// Divided timer tick, period raw_freq+1 cycles
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tdiv       <= 10'h000;
			timer_tick <= 1'b0;
		end
		else if (tdiv >= raw_freq)
		begin
			tdiv       <= 10'h000;
			timer_tick <= 1'b1;
		end
		else
		begin
			tdiv       <= tdiv + 10'h001;
			timer_tick <= 1'b0;
		end
	end

	//**********************************************
	// Sequencers
	//**********************************************
	dpc_pll_seq u_seq_a (
		.clk       (clk),
		.rstn      (rstn),
		.vco_en    (pll_a_control[`DPC_BIT_VCO_EN]),
		.rate_sw   (pll_a_control[`DPC_BIT_RATE_SW]),
		.rate_ok   (rate_ok),
		.vblank    (vblank_a),
		.row_tick  (row_tick_a),
		.lock_time (power_state_control[`DPC_LOCK_HI:`DPC_LOCK_LO]),
		.min_pd    (power_state_control[`DPC_MINPD_HI:`DPC_MINPD_LO]),
		.pll_on    (pll_on[0]),
		.locked    (locked[0]),
		.apply_div (apply_div[0])
	);

	dpc_pll_seq u_seq_b (
		.clk       (clk),
		.rstn      (rstn),
		.vco_en    (pll_b_control[`DPC_BIT_VCO_EN]),
		.rate_sw   (pll_b_control[`DPC_BIT_RATE_SW]),
		.rate_ok   (rate_ok),
		.vblank    (vblank_b),
		.row_tick  (row_tick_b),
		.lock_time (power_state_control[`DPC_LOCK_HI:`DPC_LOCK_LO]),
		.min_pd    (power_state_control[`DPC_MINPD_HI:`DPC_MINPD_LO]),
		.pll_on    (pll_on[1]),
		.locked    (locked[1]),
		.apply_div (apply_div[1])
	);

	dpc_load_pulse u_load (
		.clk_fast   (clk_fast),
		.rstn       (rstn),
		.sync_1x    (sync_1x),
		.phase      (pll_a_control[`DPC_PHASE_HI:`DPC_PHASE_LO]),
		.load_pulse (load_pulse)
	);
endmodule : dpc_ctrl

// ===== tb/dpc_ctrl_sva.sv
`timescale 1ns/10ps
`include "dpc_params.svh"

module dpc_ctrl_sva (
	input wire logic        clk,            // Clock
	input wire logic        rstn,           // Reset
	input wire logic        reg_rd,         // Read
	input wire logic [15:0] reg_addr,       // Address
	input wire logic [31:0] reg_rdata,      // Read data
	input wire logic        row_tick_a,     // Row A
	input wire logic [1:0]  pll_on,         // Power
	input wire logic [1:0]  pll_ref_en,     // Ref gate
	input wire logic [1:0]  pll_ext_buf_en, // Buffer
	input wire logic [1:0]  pll_dot_clk_en, // Dot clock
	input wire logic        pll_a_ref_sel,  // Ref select
	input wire logic        cri_clk_sel,    // CRI select
	input wire logic [1:0]  apply_div,      // Divider load
	input wire logic [9:0]  raw_freq,       // Ratio
	input wire logic        timer_tick      // Timer pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [10:0] gap;
	logic [9:0]  fq;
	logic        gv;
	logic        onq;
	logic [1:0]  offr;

	// Gap is only trusted while the ratio has not moved since the last pulse
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			gap <= 11'h000;
			fq  <= 10'h000;
			gv  <= 1'b0;
		end
		else
		begin
			gap <= timer_tick ? 11'h000 : gap + 11'h001;
			fq  <= raw_freq;
			gv  <= timer_tick | (gv & (raw_freq == fq));
		end
	end

	// Rows seen in the latest power-off of PLL A, saturating
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			onq  <= 1'b0;
			offr <= 2'h0;
		end
		else
		begin
			onq <= pll_on[0];
			if (onq & ~pll_on[0])
				offr <= {1'b0, row_tick_a};
			else if (~pll_on[0] & row_tick_a & (offr != 2'h3))
				offr <= offr + 2'h1;
		end
	end

	property p_rd_hold;
		!$past(reg_rd) |-> $stable(reg_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
	property p_unmapped;
		reg_rd && reg_addr[15:12] != 4'h6 |=> reg_rdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_a_map;
		// Buffer output is gated by PLL power, so weigh the bit against the power seen at the read
		reg_rd && reg_addr == `DPC_OFS_PLL_A_CONTROL |=> (reg_rdata[30] & $past(pll_on[0])) == pll_ext_buf_en[0]
			&& reg_rdata[29] == pll_ref_en[0] && reg_rdata[13] == pll_a_ref_sel;
	endproperty
	a_a_map: assert property (p_a_map) else $error("pll a outputs differ from register");
	property p_b_map;
		reg_rd && reg_addr == `DPC_OFS_PLL_B_CONTROL |=> (reg_rdata[30] & $past(pll_on[1])) == pll_ext_buf_en[1]
			&& reg_rdata[29] == pll_ref_en[1] && reg_rdata[14] == cri_clk_sel;
	endproperty
	a_b_map: assert property (p_b_map) else $error("pll b outputs differ from register");
	property p_dot;
		pll_dot_clk_en[0] |-> pll_on[0] || $past(pll_on[0]);
	endproperty
	a_dot: assert property (p_dot) else $error("dot clock runs with pll off");
	property p_rows;
		apply_div[0] |-> offr[1];
	endproperty
	a_rows: assert property (p_rows) else $error("dividers applied before two rows off");
	property p_tick;
		timer_tick && gv && raw_freq == fq |-> gap == {1'b0, raw_freq};
	endproperty
	a_tick: assert property (p_tick) else $error("timer pulse spacing wrong");
	property p_reset;
		$rose(rstn) |-> pll_a_ref_sel && cri_clk_sel && pll_on == 2'h0;
	endproperty
	a_reset: assert property (p_reset) else $error("bad output after reset");

	c_switch: cover property (apply_div[0]);
	c_tick: cover property (timer_tick && gv);
	c_lock: cover property ($rose(pll_dot_clk_en[0]));
endmodule : dpc_ctrl_sva

bind dpc_ctrl dpc_ctrl_sva u_sva (.clk, .rstn, .reg_rd, .reg_addr, .reg_rdata, .row_tick_a, .pll_on,
	.pll_ref_en, .pll_ext_buf_en, .pll_dot_clk_en, .pll_a_ref_sel, .cri_clk_sel, .apply_div, .raw_freq,
	.timer_tick);

// ===== tb/dpc_ctrl_tb.sv
`timescale 1ns/10ps
`include "dpc_params.svh"

module dpc_ctrl_tb;
	localparam logic [15:0] AD [5] = '{`DPC_OFS_PLL_B_CONTROL, `DPC_OFS_PLL_A_MULT_DIV,
		`DPC_OFS_PLL_B_MULT_DIV, `DPC_OFS_RAW_CLOCK_FREQ, `DPC_OFS_POWER_STATE};
	localparam logic [31:0] RS [5] = '{`DPC_RST_PLL_B_CONTROL, `DPC_RST_MULT_DIV,
		`DPC_RST_MULT_DIV, `DPC_RST_RAW_CLOCK_FREQ, `DPC_RST_POWER_STATE};
	localparam logic [31:0] WM [5] = '{`DPC_WMASK_PLL_B, `DPC_WMASK_MULT_DIV,
		`DPC_WMASK_MULT_DIV, `DPC_WMASK_RAW_FREQ, `DPC_WMASK_POWER_STATE};
	localparam logic [15:0] ACT = `DPC_OFS_PLL_A_CONTROL;
	logic            clk = 1'b0;
	logic            clk_fast = 1'b0;
	logic            rstn = 1'b0;
	logic            reg_wr = 1'b0;
	logic            reg_rd = 1'b0;
	logic [15:0]     reg_addr = 16'h0000;
	logic [31:0]     reg_wdata = 32'h00000000;
	logic            legacy_wr = 1'b0;
	logic [7:0]      legacy_data = 8'h00;
	logic [1:0]      pipe_one_cfg = 2'h0;
	logic            vblank_a = 1'b1;
	logic            vblank_b = 1'b1;
	logic            row_tick_a = 1'b0;
	logic            row_tick_b = 1'b0;
	logic [7:0]      lane_phy_state = 8'hA5;
	logic            sync_1x = 1'b0;
	wire logic [31:0] reg_rdata;
	wire logic       load_pulse, pll_a_ref_sel, cri_clk_sel, pll_share, timer_tick;
	wire logic [1:0] pll_on, pll_ref_en, pll_ext_buf_en, pll_dot_clk_en, apply_div;
	wire logic [9:0] raw_freq;
	wire logic [3:0] mult_a, mult_b;
	logic [31:0]     seed = 32'h3FBC;
	logic [31:0]     wd;
	logic [63:0]     q [$];
	logic [63:0]     ent;
	logic [2:0]      rc = 3'h0;
	logic            rd1 = 1'b0;
	int              num_errors = 0;
	int              checks_done = 0;
	int              cyc = 0;
	int              n;
	int              ph;
	int              ep;

	dpc_ctrl u_dut (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .legacy_wr,
		.legacy_data, .pipe_one_cfg, .vblank_a, .row_tick_a, .vblank_b, .row_tick_b, .lane_phy_state,
		.clk_fast, .sync_1x, .load_pulse, .pll_on, .pll_ref_en, .pll_ext_buf_en, .pll_dot_clk_en,
		.pll_a_ref_sel, .cri_clk_sel, .pll_share, .apply_div, .raw_freq, .timer_tick, .mult_a, .mult_b);

	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic complete_run();
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Expectation is queued; the monitor compares when the data lands
	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		q.push_back({m, e & m});
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask : rd

	always #20 clk = ~clk;
	always #2 clk_fast = ~clk_fast;

	always @(posedge clk)
	begin
		rd1 <= reg_rd;
		rc <= rc + 3'h1;
		row_tick_a <= (rc == 3'h7);
		row_tick_b <= (rc == 3'h3);
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			complete_run();
		end
	end

	always @(negedge clk)
		if (rd1 && q.size() > 0)
		begin
			ent = q.pop_front();
			chk(reg_rdata & ent[63:32], ent[31:0]);
		end

	// ****************
	// Sequence
	// ****************
	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		// Lane status needs three stages plus agreement before it reads back
		repeat (4) @(posedge clk);
		rd(ACT, 32'h00002CA5, 32'hFFFFFFFF);
		for (int i = 0; i < 5; i++)
		begin
			rd(AD[i], RS[i], 32'hFFFFFFFF);
			seed = xs(seed);
			// Multiplier codes kept below factor six, as for an analog port
			wd = (i == 1 || i == 2) ? seed & 32'hFFFFC3C3 : seed;
			wr(AD[i], wd);
			rd(AD[i], (wd & WM[i]) | (RS[i] & ~WM[i]), 32'hFFFFFFFF);
		end
		wr(16'h7000, seed);
		rd(16'h7000, 32'h00000000, 32'hFFFFFFFF);
		@(posedge clk);
		lane_phy_state <= seed[15:8];
		repeat (4) @(posedge clk);
		rd(ACT, 32'h00002C00 | {24'h000000, seed[15:8]}, 32'hFFFFFFFF);
		wr(`DPC_OFS_RAW_CLOCK_FREQ, 32'h00000010);
		@(negedge clk);
		chk(raw_freq, 32'h00000010);
		wr(`DPC_OFS_POWER_STATE, 32'h00100200);
		wr(`DPC_OFS_PLL_B_CONTROL, `DPC_RST_PLL_B_CONTROL);
		wr(ACT, 32'hE4002C00);
		n = 0;
		while (pll_dot_clk_en[0] !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		chk(n >= 16 && n <= 22, 32'h1);
		chk({pll_on[0], pll_share, pll_ext_buf_en[0], pll_ref_en[0], pll_a_ref_sel}, 32'h1F);
		// Toggle of the switch bit must cycle the PLL for at least the minimum off time
		wr(ACT, 32'hE4002D00);
		n = 0;
		while (pll_on[0] !== 1'b0 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		ph = 0;
		while (pll_on[0] !== 1'b1 && ph < 400)
		begin
			@(negedge clk);
			ph++;
		end
		chk(n < 100 && ph >= 2 * `DPC_MINPD_STEP_CYC && ph < 400, 32'h1);
		@(posedge clk);
		pipe_one_cfg <= 2'h1;
		wr(ACT, 32'hE4002C00);
		n = 0;
		repeat (200)
		begin
			@(negedge clk);
			n += (pll_on[0] !== 1'b1);
		end
		chk(n, 32'h0);
		wr(ACT, 32'hF4002C00);
		@(posedge clk);
		legacy_wr   <= 1'b1;
		legacy_data <= 8'h0C;
		@(posedge clk);
		legacy_wr <= 1'b0;
		repeat (3) @(posedge clk);
		chk(mult_a, 32'h0);
		chk(mult_b, 32'h3);
		wr(ACT, 32'h00002C00);
		repeat (3) @(negedge clk);
		chk({pll_on[0], pll_dot_clk_en[0], pll_ext_buf_en[0], pll_ref_en[0], pll_share}, 32'h0);
		@(posedge clk);
		legacy_wr   <= 1'b1;
		legacy_data <= 8'h04;
		@(posedge clk);
		legacy_wr <= 1'b0;
		@(negedge clk);
		chk(mult_a, 32'h1);
		ep = 6;
		for (ph = 3; ph <= 14; ph++)
		begin
			wr(ACT, 32'h00002000 | (ph << 9));
			if (ph >= 4 && ph <= 13)
				ep = ph;
			rd(ACT, 32'h00002000 | (ep << 9), 32'hFFFFFF00);
			@(posedge clk_fast);
			sync_1x <= 1'b1;
			n = 0;
			while (load_pulse !== 1'b1 && n < 40)
			begin
				@(negedge clk_fast);
				n++;
			end
			chk(n, ep + 3);
			@(posedge clk_fast);
			sync_1x <= 1'b0;
			repeat (2) @(posedge clk);
		end
		complete_run();
	end
endmodule : dpc_ctrl_tb
